// ### core/adc_seq_pkg.sv
// ==========================================================
// register map, field layout and sequencing constants
package adc_seq_pkg;

    // ==========================================================
    // register byte addresses
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] TIMING_ADDR = 8'h04;
    localparam logic [7:0] RESULT_ADDR = 8'h08;

    // ==========================================================
    // control register bit positions
    localparam int CTRL_BUSY_BIT  = 0;
    localparam int CTRL_SRC_LSB   = 1;
    localparam int CTRL_SRC_W     = 2;
    localparam int CTRL_TRACK_BIT = 3;
    localparam int CTRL_BURST_BIT = 4;
    localparam int CTRL_KEEP_BIT  = 5;
    localparam int CTRL_EIGHT_BIT = 6;
    localparam int CTRL_TWELV_BIT = 7;
    localparam int CTRL_HOLD_BIT  = 8;
    localparam int CTRL_DONE_BIT  = 9;

    // ==========================================================
    // timing register fields
    localparam int TIM_TRACK_LSB = 0;
    localparam int TIM_TRACK_W   = 6;
    localparam int TIM_PWR_LSB   = 8;
    localparam int TIM_PWR_W     = 6;
    localparam int TIM_DIV_LSB   = 16;
    localparam int TIM_DIV_W     = 4;
    localparam int TIM_RPT_LSB   = 20;
    localparam int TIM_RPT_W     = 3;

    // ==========================================================
    // reset values
    localparam logic [1:0] SRC_RESET   = 2'h0;
    localparam logic [5:0] TRACK_RESET = 6'h00;
    localparam logic [5:0] PWR_RESET   = 6'h00;
    localparam logic [3:0] DIV_RESET   = 4'h0;
    localparam logic [2:0] RPT_RESET   = 3'h0;

    // ==========================================================
    // trigger source codes
    localparam logic [1:0] SRC_SOFTWARE = 2'h0;
    localparam logic [1:0] SRC_INTERNAL = 2'h1;
    localparam logic [1:0] SRC_PIN      = 2'h2;

    // ==========================================================
    // timing in sar clocks and repeat count limits
    localparam logic [7:0] TRACK_MODE_CLKS = 8'h04;
    localparam logic [7:0] CONV_CLKS_TEN   = 8'h0a;
    localparam logic [7:0] CONV_CLKS_EIGHT = 8'h08;
    localparam logic [2:0] RPT_MAX_CODE    = 3'h5;
    localparam logic [2:0] RPT_MAX_SHIFT   = 3'h6;

    // ==========================================================
    // sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE    = 2'b00,
        SEQ_POWERUP = 2'b01,
        SEQ_TRACK   = 2'b10,
        SEQ_CONVERT = 2'b11
    } seq_state_e;

endpackage : adc_seq_pkg

// ### core/adc_conv_seq.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps

module adc_conv_seq #(
    parameter int CODE_W = 10
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic      [31:0] rd_data,
    input  wire logic        internal_trigger,
    input  wire logic        ext_convert_start_pin,
    input  wire logic        hf_osc_tick,
    input  wire logic [9:0]  sample_code,
    output logic             adc_power,
    output logic             adc_track,
    output logic             adc_convert,
    output logic      [1:0]  ref_step,
    output logic             conversion_done_flag,
    output logic             conversion_busy_bit,
    output logic             window_eval,
    output logic      [7:0]  result_high_byte,
    output logic      [7:0]  result_low_byte
);

    // ==========================================================
    // elaboration check
    if (CODE_W != 10)
    begin : g_bad_width
        $error("adc_conv_seq: converter code width must be 10");
    end

    // ==========================================================
    // state
    typedef struct packed {
        adc_seq_pkg::seq_state_e state;
        logic [1:0]  src;
        logic        track_mode;
        logic        burst;
        logic        idle_keep;
        logic        eight;
        logic        twelve;
        logic        hold;
        logic        done;
        logic        busy;
        logic [5:0]  trk_time;
        logic [5:0]  pwr_time;
        logic [3:0]  div;
        logic [2:0]  rpt;
        logic [3:0]  div_cnt;
        logic        sar_tick;
        logic [7:0]  timer;
        logic [6:0]  count;
        logic [15:0] acc;
        logic [15:0] result;
        logic        powered;
        logic        pin_prev;
        logic        track;
        logic        convert;
        logic        power;
        logic [1:0]  ref_step;
        logic        window_eval;
        logic [31:0] rd_data;
    } seq_s;

    seq_s st_reg;
    seq_s st_next;

    logic        start;
    logic        conv_end;
    logic        last_conv;
    logic        twelve_on;
    logic [6:0]  target;
    logic [2:0]  rpt_shift;
    logic [7:0]  conv_len;
    logic [7:0]  first_len;
    logic [7:0]  next_len;
    logic [15:0] sum;
    logic [9:0]  code;

    // ==========================================================
    // derived terms
    always_comb
    begin
        unique case (st_reg.src)
            adc_seq_pkg::SRC_SOFTWARE: start = wr_en && addr == adc_seq_pkg::CTRL_ADDR
                                               && wr_data[adc_seq_pkg::CTRL_BUSY_BIT];
            adc_seq_pkg::SRC_INTERNAL: start = internal_trigger;
            adc_seq_pkg::SRC_PIN:      start = ext_convert_start_pin && !st_reg.pin_prev;
            default:                   start = 1'b0;
        endcase
        if (st_reg.rpt == 3'h0)
            rpt_shift = 3'h0;
        else if (st_reg.rpt >= adc_seq_pkg::RPT_MAX_CODE)
            rpt_shift = adc_seq_pkg::RPT_MAX_SHIFT;
        else
            rpt_shift = st_reg.rpt + 3'h1;
        target    = 7'h01 << rpt_shift;
        twelve_on = st_reg.twelve && st_reg.burst && st_reg.rpt != 3'h0;
        conv_len  = st_reg.eight ? adc_seq_pkg::CONV_CLKS_EIGHT
                                 : adc_seq_pkg::CONV_CLKS_TEN;
        // pin trigger outside burst has already tracked while the pin was low
        if (st_reg.track_mode && (st_reg.burst || st_reg.src != adc_seq_pkg::SRC_PIN))
            first_len = adc_seq_pkg::TRACK_MODE_CLKS;
        else
            first_len = 8'h00;
        if (twelve_on && st_reg.hold && st_reg.count[1:0] != 2'h3)
            next_len = 8'h00;
        else
            next_len = {2'h0, st_reg.trk_time}
                     + (st_reg.track_mode ? adc_seq_pkg::TRACK_MODE_CLKS : 8'h00);
        conv_end  = st_reg.state == adc_seq_pkg::SEQ_CONVERT && st_reg.sar_tick
                    && st_reg.timer == 8'h00;
        last_conv = st_reg.count + 7'h01 == target;
        code      = st_reg.eight ? {sample_code[9:2], 2'b00} : sample_code;
        sum       = (st_reg.count == 7'h00 ? 16'h0000 : st_reg.acc) + {6'h00, code};
    end

    // ==========================================================
    // next state
    always_comb
    begin
        logic       launch;
        logic [7:0] launch_len;
        launch         = 1'b0;
        launch_len     = 8'h00;
        st_next        = st_reg;
        st_next.sar_tick    = 1'b0;
        st_next.window_eval = 1'b0;
        st_next.rd_data     = 32'h0000_0000;
        st_next.pin_prev    = ext_convert_start_pin;

        // sar clock enable from the selected source
        if (st_reg.burst ? hf_osc_tick : 1'b1)
        begin
            if (st_reg.div_cnt >= st_reg.div)
            begin
                st_next.div_cnt  = 4'h0;
                st_next.sar_tick = 1'b1;
            end
            else
                st_next.div_cnt = st_reg.div_cnt + 4'h1;
        end

        // register writes
        if (wr_en && addr == adc_seq_pkg::CTRL_ADDR)
        begin
            st_next.src        = wr_data[adc_seq_pkg::CTRL_SRC_LSB +: adc_seq_pkg::CTRL_SRC_W];
            st_next.track_mode = wr_data[adc_seq_pkg::CTRL_TRACK_BIT];
            st_next.burst      = wr_data[adc_seq_pkg::CTRL_BURST_BIT];
            st_next.idle_keep  = wr_data[adc_seq_pkg::CTRL_KEEP_BIT];
            st_next.eight      = wr_data[adc_seq_pkg::CTRL_EIGHT_BIT];
            st_next.twelve     = wr_data[adc_seq_pkg::CTRL_TWELV_BIT];
            st_next.hold       = wr_data[adc_seq_pkg::CTRL_HOLD_BIT];
            if (wr_data[adc_seq_pkg::CTRL_DONE_BIT])
                st_next.done = 1'b0;
        end
        if (wr_en && addr == adc_seq_pkg::TIMING_ADDR)
        begin
            st_next.trk_time = wr_data[adc_seq_pkg::TIM_TRACK_LSB +: adc_seq_pkg::TIM_TRACK_W];
            st_next.pwr_time = wr_data[adc_seq_pkg::TIM_PWR_LSB +: adc_seq_pkg::TIM_PWR_W];
            st_next.div      = wr_data[adc_seq_pkg::TIM_DIV_LSB +: adc_seq_pkg::TIM_DIV_W];
            st_next.rpt      = wr_data[adc_seq_pkg::TIM_RPT_LSB +: adc_seq_pkg::TIM_RPT_W];
        end
        if (!st_reg.burst)
            st_next.powered = 1'b1;

        // sequencer; starts outside idle fall through, which drops them
        unique case (st_reg.state)
            adc_seq_pkg::SEQ_IDLE:
            begin
                if (start)
                begin
                    st_next.busy = 1'b1;
                    if (st_reg.burst && !st_reg.powered)
                    begin
                        st_next.state = adc_seq_pkg::SEQ_POWERUP;
                        st_next.timer = (st_reg.pwr_time == 6'h00) ? 8'h00
                                      : {2'h0, st_reg.pwr_time - 6'h01};
                    end
                    else
                    begin
                        launch     = 1'b1;
                        launch_len = first_len;
                    end
                end
            end
            adc_seq_pkg::SEQ_POWERUP:
            begin
                if (st_reg.sar_tick)
                begin
                    if (st_reg.timer == 8'h00)
                    begin
                        st_next.powered = 1'b1;
                        launch          = 1'b1;
                        launch_len      = first_len;
                    end
                    else
                        st_next.timer = st_reg.timer - 8'h01;
                end
            end
            adc_seq_pkg::SEQ_TRACK:
            begin
                if (st_reg.sar_tick)
                begin
                    if (st_reg.timer == 8'h00)
                    begin
                        st_next.state = adc_seq_pkg::SEQ_CONVERT;
                        st_next.timer = conv_len - 8'h01;
                    end
                    else
                        st_next.timer = st_reg.timer - 8'h01;
                end
            end
            adc_seq_pkg::SEQ_CONVERT:
            begin
                if (st_reg.sar_tick && st_reg.timer != 8'h00)
                    st_next.timer = st_reg.timer - 8'h01;
                if (conv_end)
                begin
                    st_next.acc = sum;
                    if (last_conv)
                    begin
                        st_next.count       = 7'h00;
                        st_next.state       = adc_seq_pkg::SEQ_IDLE;
                        st_next.busy        = 1'b0;
                        st_next.done        = 1'b1;
                        st_next.window_eval = 1'b1;
                        st_next.result      = st_reg.eight ? {sum[9:2], 8'h00} : sum;
                        if (st_reg.burst && !st_reg.idle_keep)
                            st_next.powered = 1'b0;
                    end
                    else
                    begin
                        st_next.count = st_reg.count + 7'h01;
                        if (st_reg.burst)
                        begin
                            launch     = 1'b1;
                            launch_len = next_len;
                        end
                        else
                        begin
                            st_next.state = adc_seq_pkg::SEQ_IDLE;
                            st_next.busy  = 1'b0;
                        end
                    end
                end
            end
        endcase

        if (launch)
        begin
            if (launch_len == 8'h00)
            begin
                st_next.state = adc_seq_pkg::SEQ_CONVERT;
                st_next.timer = conv_len - 8'h01;
            end
            else
            begin
                st_next.state = adc_seq_pkg::SEQ_TRACK;
                st_next.timer = launch_len - 8'h01;
            end
        end

        // analog controls
        st_next.convert  = st_next.state == adc_seq_pkg::SEQ_CONVERT;
        st_next.track    = st_next.state == adc_seq_pkg::SEQ_TRACK
                           || (st_next.state == adc_seq_pkg::SEQ_IDLE && !st_reg.burst
                               && (!st_reg.track_mode
                                   || (st_reg.src == adc_seq_pkg::SRC_PIN
                                       && !ext_convert_start_pin)));
        st_next.power    = st_next.powered || st_next.state != adc_seq_pkg::SEQ_IDLE;
        st_next.ref_step = twelve_on ? st_next.count[1:0] : 2'h0;
        // done set wins over a clear in the same cycle
        if (conv_end && last_conv)
            st_next.done = 1'b1;

        // register reads, answer in the following cycle only
        if (rd_en)
        begin
            unique case (addr)
                adc_seq_pkg::CTRL_ADDR:
                    st_next.rd_data = {22'h000000, st_reg.done, st_reg.hold, st_reg.twelve,
                                       st_reg.eight, st_reg.idle_keep, st_reg.burst,
                                       st_reg.track_mode, st_reg.src, st_reg.busy};
                adc_seq_pkg::TIMING_ADDR:
                    st_next.rd_data = {9'h000, st_reg.rpt, st_reg.div, 2'h0, st_reg.pwr_time,
                                       2'h0, st_reg.trk_time};
                adc_seq_pkg::RESULT_ADDR:
                    st_next.rd_data = {16'h0000, st_reg.result};
                default:
                    st_next.rd_data = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_reg          <= '0;
            st_reg.state    <= adc_seq_pkg::SEQ_IDLE;
            st_reg.src      <= adc_seq_pkg::SRC_RESET;
            st_reg.trk_time <= adc_seq_pkg::TRACK_RESET;
            st_reg.pwr_time <= adc_seq_pkg::PWR_RESET;
            st_reg.div      <= adc_seq_pkg::DIV_RESET;
            st_reg.rpt      <= adc_seq_pkg::RPT_RESET;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign rd_data              = st_reg.rd_data;
    assign adc_power            = st_reg.power;
    assign adc_track            = st_reg.track;
    assign adc_convert          = st_reg.convert;
    assign ref_step             = st_reg.ref_step;
    assign conversion_done_flag = st_reg.done;
    assign conversion_busy_bit  = st_reg.busy;
    assign window_eval          = st_reg.window_eval;
    assign result_high_byte     = st_reg.result[15:8];
    assign result_low_byte      = st_reg.result[7:0];

    // ==========================================================
    // checks
    a_sw_start_busy: assert property (@(posedge clk) disable iff (rst)
        st_reg.state == adc_seq_pkg::SEQ_IDLE && st_reg.src == adc_seq_pkg::SRC_SOFTWARE
        && wr_en && addr == adc_seq_pkg::CTRL_ADDR && wr_data[0]
        |=> st_reg.busy && st_reg.state != adc_seq_pkg::SEQ_IDLE)
        else $error("software start did not begin a conversion");
    a_internal_start: assert property (@(posedge clk) disable iff (rst)
        st_reg.state == adc_seq_pkg::SEQ_IDLE && st_reg.src == adc_seq_pkg::SRC_INTERNAL
        && internal_trigger |=> st_reg.busy)
        else $error("internal event did not begin a conversion");
    a_pin_edge_start: assert property (@(posedge clk) disable iff (rst)
        st_reg.state == adc_seq_pkg::SEQ_IDLE && st_reg.src == adc_seq_pkg::SRC_PIN
        && $rose(ext_convert_start_pin) |=> st_reg.busy)
        else $error("pin rising edge did not begin a conversion");
    a_other_ignored: assert property (@(posedge clk) disable iff (rst)
        st_reg.state == adc_seq_pkg::SEQ_IDLE && st_reg.src != adc_seq_pkg::SRC_INTERNAL
        && internal_trigger && !start |=> !st_reg.busy)
        else $error("unselected trigger started a conversion");
    a_busy_clears: assert property (@(posedge clk) disable iff (rst)
        conv_end && (last_conv || !st_reg.burst) |=> !st_reg.busy
        && st_reg.state == adc_seq_pkg::SEQ_IDLE)
        else $error("busy not cleared at conversion end");
    a_done_at_count: assert property (@(posedge clk) disable iff (rst)
        $rose(st_reg.done) |-> $past(conv_end) && $past(last_conv) && st_reg.window_eval)
        else $error("done flag set before repeat count reached");
    a_result_held: assert property (@(posedge clk) disable iff (rst)
        conv_end && !last_conv |=> $stable(st_reg.result) && !st_reg.window_eval)
        else $error("result changed before last conversion");
    a_track_four: assert property (@(posedge clk) disable iff (rst)
        st_reg.state == adc_seq_pkg::SEQ_IDLE && st_reg.track_mode && !st_reg.burst
        && st_reg.src != adc_seq_pkg::SRC_PIN && start
        |=> st_reg.state == adc_seq_pkg::SEQ_TRACK && st_reg.timer == 8'h03)
        else $error("track mode did not insert four sar clocks");
    a_powerup_ignore: assert property (@(posedge clk) disable iff (rst)
        st_reg.state == adc_seq_pkg::SEQ_POWERUP && start |=> st_reg.busy
        && (st_reg.state != adc_seq_pkg::SEQ_POWERUP || st_reg.timer <= $past(st_reg.timer)))
        else $error("start during burst disturbed the sequence");
    a_eight_low_zero: assert property (@(posedge clk) disable iff (rst)
        conv_end && last_conv && st_reg.eight |=> result_low_byte == 8'h00)
        else $error("eight bit mode low byte not zero");

endmodule : adc_conv_seq

// ### dv/adc_far_side.sv
`timescale 1ns/10ps
// ==========================================================
// far side: start pin driver, oscillator ticks, converter core
module adc_far_side (
    input  wire logic       clk,
    input  wire logic       fire,
    input  wire logic       adc_convert,
    input  wire logic [9:0] code_val,
    output logic            ext_convert_start_pin,
    output logic            hf_osc_tick,
    output logic      [9:0] sample_code
);
    logic [2:0] hi_cnt;

    initial
    begin
        hi_cnt = 3'h0;
        ext_convert_start_pin = 1'b0;
        hf_osc_tick = 1'b0;
    end

    // eight-cycle frame: four high, four low; a fire inside a frame is dropped
    always @(posedge clk)
    begin
        hf_osc_tick <= ~hf_osc_tick;
        if (hi_cnt != 3'h0 || fire)
            hi_cnt <= hi_cnt + 3'h1;
        ext_convert_start_pin <= (hi_cnt == 3'h0) ? fire : (hi_cnt < 3'h4);
    end

    // core output is not valid outside conversion
    assign sample_code = adc_convert ? code_val : ~code_val;
endmodule : adc_far_side

// ### dv/sar_adc_conversion_sequencer_test.sv
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, e); end end
module sar_adc_conversion_sequencer_test;
    localparam logic [9:0] code_v = 10'h2a5;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wr_data = 32'h0;
    logic        wr_en = 1'b0;
    logic        rd_en = 1'b0;
    logic        internal_trigger = 1'b0;
    logic        fire = 1'b0;
    logic [31:0] rd_data, rdv;
    logic        pin, tick, pwr, trk, cnv, done, busy, wev;
    logic [9:0]  code;
    logic [1:0]  ref_step;
    logic [7:0]  res_hi, res_lo;
    int          err_count = 0;
    int          total_checks = 0;
    int          wev_cnt = 0;
    int          cnv_cnt = 0;
    int          i, k;
    // sw, internal+track div 1, pin+track, eight-bit, burst x4,
    // burst keep x8 after power-up, twelve-bit hold kept on
    logic [31:0] cfgs [7] = '{32'h0, 32'ha, 32'hc, 32'h40, 32'h12, 32'h3a, 32'h1b0};
    logic [31:0] tims [7] = '{32'h0, 32'h10000, 32'h0, 32'h0, 32'h100203, 32'h200405, 32'h10003f};
    logic [15:0] exps [7] = '{16'h2a5, 16'h2a5, 16'h2a5, 16'ha900, 16'ha94, 16'h1528, 16'ha94};
    logic [1:0]  refs [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3};
    logic        trks [7] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic        pwrs [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    // converting cycles of the single-conversion tests
    int          cvs [4] = '{10, 20, 10, 8};

    always #2 clk = ~clk;
    always @(negedge clk)
        if (wev === 1'b1) wev_cnt++;
    always @(negedge clk)
        if (cnv === 1'b1) cnv_cnt++;

    adc_far_side far (.clk(clk), .fire(fire), .adc_convert(cnv), .code_val(code_v),
        .ext_convert_start_pin(pin), .hf_osc_tick(tick), .sample_code(code));

    adc_conv_seq uut (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
        .rd_en(rd_en), .rd_data(rd_data), .internal_trigger(internal_trigger),
        .ext_convert_start_pin(pin), .hf_osc_tick(tick), .sample_code(code),
        .adc_power(pwr), .adc_track(trk), .adc_convert(cnv), .ref_step(ref_step),
        .conversion_done_flag(done), .conversion_busy_bit(busy), .window_eval(wev),
        .result_high_byte(res_hi), .result_low_byte(res_lo));

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        rdv = rd_data;
    endtask : rd

    task automatic run(input int n);
        logic [1:0] mx;
        logic       sb;
        int         w0;
        int         c0;
        mx = 2'h0;
        sb = 1'b0;
        w0 = wev_cnt;
        c0 = cnv_cnt;
        wr(8'h04, tims[n]);
        wr(8'h00, cfgs[n] | 32'h200);
        if (cfgs[n][2:1] == 2'h0)
            wr(8'h00, cfgs[n] | 32'h1);
        @(posedge clk);
        internal_trigger <= (cfgs[n][2:1] == 2'h1);
        fire <= (cfgs[n][2:1] == 2'h2);
        @(posedge clk);
        internal_trigger <= 1'b0;
        fire <= 1'b0;
        repeat (3) @(posedge clk);
        internal_trigger <= (cfgs[n][2:1] == 2'h1);
        @(posedge clk);
        internal_trigger <= 1'b0;
        for (k = 0; k < 1500 && done !== 1'b1; k++)
        begin
            @(negedge clk);
            if (busy === 1'b1) sb = 1'b1;
            if (ref_step > mx) mx = ref_step;
        end
        repeat (40) @(negedge clk);
        `CHK(sb, 1'b1)
        `CHK(done, 1'b1)
        `CHK(busy, 1'b0)
        `CHK(mx, refs[n])
        `CHK(wev_cnt - w0, 1)
        `CHK({res_hi, res_lo}, exps[n])
        `CHK(trk, trks[n])
        `CHK(pwr, pwrs[n])
        if (n < 4)
            `CHK(cnv_cnt - c0, cvs[n])
        rd(8'h08);
        `CHK(rdv[15:0], exps[n])
        $display("test %0d done", n);
    endtask : run

    task automatic results();
        $display("checks=%0d mismatches=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        results();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00);
        `CHK(rdv, 32'h0)
        rd(8'h0c);
        `CHK(rdv, 32'h0)
        wr(8'h04, 32'h00100203);
        rd(8'h04);
        `CHK(rdv, 32'h00100203)
        // software source selected: other sources must not start
        wr(8'h00, 32'h200);
        @(posedge clk);
        internal_trigger <= 1'b1;
        fire <= 1'b1;
        @(posedge clk);
        internal_trigger <= 1'b0;
        fire <= 1'b0;
        repeat (20) @(negedge clk);
        `CHK(busy, 1'b0)
        `CHK(done, 1'b0)
        $display("test unselected done");
        for (i = 0; i < 7; i++)
            run(i);
        results();
    end
endmodule : sar_adc_conversion_sequencer_test
